/* pkg/bsx_pkg.sv */
package bsx_pkg;
  // ******************************
  // Word and operand layout
  // ******************************
  localparam int IW = 14;
  localparam int DW = 8;
  localparam int FW = 7;
  localparam int PCW = 13;
  localparam int BRW = 11;
  localparam int DEST_BIT = 7;
  localparam int BIT_LSB = 7;
  localparam int LATCH_LSB = 3;
  localparam int BRANCH_CYCLES = 2;
  localparam int SKIP_CYCLES = 2;

  // Opcode patterns
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
  localparam logic [3:0] OPC_BIT_SET = 4'h5;
  localparam logic [3:0] OPC_BIT_TEST = 4'h6;
  localparam logic [2:0] OPC_BRANCH = 3'h5;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OPC_INC = 6'h0A;
  localparam logic [5:0] OPC_MOVE_REG = 6'h08;
  localparam logic [5:0] OPC_SWAP = 6'h0E;
  localparam logic [6:0] OPC_STORE_ACC = 7'h01;
  localparam logic [IW-1:0] OPC_OPTION_LOAD = 14'h0062;
  localparam logic [10:0] OPC_DIR_LOAD = 11'h00C;
  localparam logic [2:0] DIR_MIN = 3'h5;

  // Reset values
  localparam logic [DW-1:0] ACC_RESET = 8'h00;
  localparam logic [DW-1:0] OPTION_RESET = 8'hFF;
  localparam logic [DW-1:0] DIR_RESET = 8'hFF;

  // File write request
  typedef struct packed {
    logic          we;
    logic [FW-1:0] addr;
    logic [DW-1:0] data;
  } bsx_fwrite_t;
endpackage

/* design/bsx_alu.sv */
`timescale 1ns/100ps
module bsx_alu
  import bsx_pkg::*;
(
  input  wire logic [3:0]    op_sel,
  input  wire logic [DW-1:0] opnd,
  input  wire logic [2:0]    bit_sel,
  output logic      [DW-1:0] result,
  output logic               zero
);
  // ******************************
  // Result selector
  // ******************************
  // 0 clr,1 set,2 dec,3 inc,4 move,5 swap
  always_comb begin
    unique case (op_sel)
      4'h0: result = opnd & ~(8'h01 << bit_sel);
      4'h1: result = opnd | (8'h01 << bit_sel);
      4'h2: result = opnd - 8'h01;
      4'h3: result = opnd + 8'h01;  // 0xFF wraps to zero
      4'h5: result = {opnd[3:0], opnd[7:4]};
      default: result = opnd;
    endcase
    zero = (result == 8'h00);
  end
endmodule // bsx_alu

/* design/bsx_exec.sv */
`timescale 1ns/100ps
// Summary of operation
// - Bit clear zeroes one chosen bit of the file register, other bits and flags untouched.
// - Bit set forces one chosen bit to one, other bits and flags untouched.
// - Bit test skips the prefetched word as a no-op when the bit is zero, else one cycle.
// - Decrement-skip writes f minus one to accumulator or file by destination, flags kept.
// - A zero decrement result discards the prefetched word, taking two cycles.
// - The branch loads its 11-bit field into counter bits 10:0 and always takes two cycles.
// - Counter bits 12:11 come from bits 4:3 of the upper address latch on a branch.
// - Increment adds one, steers by destination and updates zero; 0xFF wraps to zero.
// - Destination 0 sends the result to the accumulator, 1 back to the file register.
// - Move register copies f to the destination and updates zero.
// - Store accumulator writes the accumulator into f in one cycle, flags kept.
// - Option load copies the accumulator into the option register in one cycle.
// - Nibble exchange swaps the halves of f, steers by destination, flags kept.
// - Direction load copies the accumulator into direction register 5 to 7 only.
module bsx_exec
  import bsx_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire logic              instr_valid,
  input  wire logic [IW-1:0]     instr_word,
  input  wire logic [DW-1:0]     file_rdata,
  input  wire logic [DW-1:0]     upper_address_latch,
  input  wire logic [PCW-1:0]    pc_in,
  output logic      [FW-1:0]     file_raddr,
  output bsx_fwrite_t            file_wr,
  output logic      [DW-1:0]     acc_out,
  output logic                   zero_flag,
  output logic                   zero_we,
  output logic      [DW-1:0]     option_out,
  output logic      [DW-1:0]     dir_a_out,
  output logic      [DW-1:0]     dir_b_out,
  output logic      [DW-1:0]     dir_c_out,
  output logic                   pc_load,
  output logic      [PCW-1:0]    pc_target,
  output logic                   flush,
  output logic                   busy
);
  // ******************************
  // State
  // ******************************
  typedef enum logic [0:0] {ST_EXEC, ST_BUBBLE} bsx_state_t;
  typedef struct packed {
    bsx_state_t          st;
    logic [DW-1:0]       acc;
    logic                zf;
    logic                zwe;
    logic [DW-1:0]       opt;
    logic [2:0][DW-1:0]  dir;
    bsx_fwrite_t         fw;
    logic                pcl;
    logic [PCW-1:0]      pct;
    logic                fl;
  } bsx_state_s_t;

  bsx_state_s_t state_reg, state_next;
  logic [3:0]    alu_sel;
  logic [DW-1:0] alu_res;
  logic          alu_zero;
  logic          is_clr, is_set, is_tst, is_br, is_dec, is_inc, is_mov, is_swp;
  logic          is_sto, is_opt, is_dir, dest_f;
  logic [2:0]    bsel;
  logic [1:0]    dir_idx;

  // Opcode decode; file read is combinational from the current word
  always_comb begin
    is_clr = instr_word[13:10] == OPC_BIT_CLEAR;
    is_set = instr_word[13:10] == OPC_BIT_SET;
    is_tst = instr_word[13:10] == OPC_BIT_TEST;
    is_br  = instr_word[13:11] == OPC_BRANCH;
    is_dec = instr_word[13:8] == OPC_DEC_SKIP;
    is_inc = instr_word[13:8] == OPC_INC;
    is_mov = instr_word[13:8] == OPC_MOVE_REG;
    is_swp = instr_word[13:8] == OPC_SWAP;
    is_sto = instr_word[13:7] == OPC_STORE_ACC;
    is_opt = instr_word == OPC_OPTION_LOAD;
    is_dir = instr_word[13:3] == OPC_DIR_LOAD && instr_word[2:0] >= DIR_MIN;
    dest_f = instr_word[DEST_BIT];
    bsel   = instr_word[BIT_LSB+2:BIT_LSB];
    // Operand 5..7 onto slots 0..2; other operands never reach the write
    dir_idx = 2'(instr_word[2:0] - DIR_MIN);
    unique case (1'b1)
      is_clr:  alu_sel = 4'h0;
      is_set:  alu_sel = 4'h1;
      is_dec:  alu_sel = 4'h2;
      is_inc:  alu_sel = 4'h3;
      is_swp:  alu_sel = 4'h5;
      default: alu_sel = 4'h4;
    endcase
  end

  assign file_raddr = instr_word[FW-1:0];

  bsx_alu u_alu (
    .op_sel  (alu_sel),
    .opnd    (file_rdata),
    .bit_sel (bsel),
    .result  (alu_res),
    .zero    (alu_zero)
  );

  // ******************************
  // Next-state logic
  // ******************************
  // Strobes last one cycle; the bubble cycle executes as a no-op
  always_comb begin
    state_next     = state_reg;
    state_next.fw  = '0;
    state_next.zwe = 1'b0;
    state_next.pcl = 1'b0;
    state_next.fl  = 1'b0;
    if (state_reg.st == ST_BUBBLE) begin
      state_next.st = ST_EXEC;  // Discarded word costs the second cycle
    end else if (instr_valid) begin
      state_next.fw.addr = instr_word[FW-1:0];
      if (is_clr || is_set) begin
        state_next.fw.we   = 1'b1;
        state_next.fw.data = alu_res;
      end
      if (is_dec || is_inc || is_mov || is_swp) begin
        if (dest_f) begin
          state_next.fw.we   = 1'b1;
          state_next.fw.data = alu_res;
        end else begin
          state_next.acc = alu_res;
        end
      end
      if (is_inc || is_mov) begin
        state_next.zf  = alu_zero;
        state_next.zwe = 1'b1;
      end
      if (is_sto) begin
        state_next.fw.we   = 1'b1;
        state_next.fw.data = state_reg.acc;
      end
      if (is_opt) begin
        state_next.opt = state_reg.acc;
      end
      if (is_dir) begin
        state_next.dir[dir_idx] = state_reg.acc;
      end
      if (is_br) begin
        state_next.pcl = 1'b1;
        state_next.pct = {upper_address_latch[LATCH_LSB+1:LATCH_LSB],
                          instr_word[BRW-1:0]};
        state_next.fl  = 1'b1;
        state_next.st  = ST_BUBBLE;
      end
      if ((is_tst && !file_rdata[bsel]) || (is_dec && alu_zero)) begin
        state_next.fl = 1'b1;
        state_next.st = ST_BUBBLE;
      end
    end
  end

  // Whole state registered in one place
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg     <= '0;
      state_reg.st  <= ST_EXEC;
      state_reg.acc <= ACC_RESET;
      state_reg.opt <= OPTION_RESET;
      state_reg.dir <= {3{DIR_RESET}};
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign file_wr    = state_reg.fw;
  assign acc_out    = state_reg.acc;
  assign zero_flag  = state_reg.zf;
  assign zero_we    = state_reg.zwe;
  assign option_out = state_reg.opt;
  assign dir_a_out  = state_reg.dir[0];
  assign dir_b_out  = state_reg.dir[1];
  assign dir_c_out  = state_reg.dir[2];
  assign pc_load    = state_reg.pcl;
  assign pc_target  = state_reg.pct;
  assign flush      = state_reg.fl;
  // Busy is high in the bubble so the fetch side can hold off
  assign busy       = state_reg.st == ST_BUBBLE;

  // ******************************
  // Checks
  // ******************************
  chk_branch_target: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && instr_valid && !busy && is_br |=> pc_load &&
      pc_target == {$past(upper_address_latch[4:3]), $past(instr_word[10:0])})
    else $error("branch target wrong");
  chk_branch_bubble: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && instr_valid && !busy && is_br |=> busy && flush)
    else $error("branch not two cycles");
  chk_test_skip: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && instr_valid && !busy && is_tst |=> busy == $past(!file_rdata[bsel]))
    else $error("bit test skip wrong");
  chk_dec_skip: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && instr_valid && !busy && is_dec |=> busy == ($past(file_rdata) == 8'h01))
    else $error("decrement skip wrong");
  chk_clear_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && instr_valid && !busy && is_clr |=> file_wr.we &&
      file_wr.data == ($past(file_rdata) & ~(8'h01 << $past(bsel))) && !zero_we)
    else $error("bit clear wrong");
  chk_set_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && instr_valid && !busy && is_set |=> file_wr.we &&
      file_wr.data == ($past(file_rdata) | (8'h01 << $past(bsel))) && !zero_we)
    else $error("bit set wrong");
  chk_inc_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && instr_valid && !busy && is_inc && file_rdata == 8'hFF |=> zero_we && zero_flag)
    else $error("increment wrap wrong");
  chk_store_acc: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && instr_valid && !busy && is_sto |=> file_wr.we &&
      file_wr.data == $past(acc_out) && !busy)
    else $error("store accumulator wrong");
  chk_option_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && instr_valid && !busy && is_opt |=> option_out == $past(acc_out))
    else $error("option load wrong");
endmodule // bsx_exec

/* verif/bsx_file_model.sv */
`timescale 1ns/100ps
module bsx_file_model
  import bsx_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic [FW-1:0] file_raddr,
  input  wire bsx_fwrite_t   file_wr,
  output logic      [DW-1:0] file_rdata
);
  // ************
  // File space
  // ************
  logic [DW-1:0] mem [0:127];

  // Same-cycle read, the core fetches operands without a wait state
  assign file_rdata = mem[file_raddr];

  // Plain always so the bench may also preload cells
  always @(posedge sys_clk) begin
    if (file_wr.we) begin
      mem[file_wr.addr] <= file_wr.data;
    end
  end
endmodule // bsx_file_model

/* verif/test_bit_skip_branch_move_exec.sv */
`timescale 1ns/100ps
module test_bit_skip_branch_move_exec import bsx_pkg::*;;
  logic sys_clk, rst_b, clk_en, instr_valid;
  logic [IW-1:0] instr_word;
  logic [DW-1:0] file_rdata, upper_address_latch, acc_out, option_out;
  logic [DW-1:0] dir_a_out, dir_b_out, dir_c_out;
  logic [FW-1:0] file_raddr;
  logic [PCW-1:0] pc_target;
  logic zero_flag, zero_we, pc_load, flush, busy;
  bsx_fwrite_t file_wr;
  int bad_count = 0;
  int checks = 0;

  bsx_exec u_bsx_exec (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr_word(instr_word), .file_rdata(file_rdata),
    .upper_address_latch(upper_address_latch), .pc_in(13'h0000),
    .file_raddr(file_raddr), .file_wr(file_wr), .acc_out(acc_out),
    .zero_flag(zero_flag), .zero_we(zero_we), .option_out(option_out),
    .dir_a_out(dir_a_out), .dir_b_out(dir_b_out), .dir_c_out(dir_c_out),
    .pc_load(pc_load), .pc_target(pc_target), .flush(flush), .busy(busy));
  bsx_file_model u_bsx_file_model (.sys_clk(sys_clk), .file_raddr(file_raddr),
    .file_wr(file_wr), .file_rdata(file_rdata));

  // ************
  // Helpers
  // ************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One word, then an idle cycle; returns with the answer settled
  task automatic issue(input logic [IW-1:0] w);
    @(posedge sys_clk);
    instr_word  <= w;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // Two words back to back; the second lands in the bubble and must vanish
  task automatic issue2(input logic [IW-1:0] w1, input logic [IW-1:0] w2,
                        output logic [2:0] fb, output logic [15:0] wr);
    @(posedge sys_clk);
    instr_word  <= w1;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_word  <= w2;
    #1;
    fb = {pc_load, flush, busy};
    wr = file_wr;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // ************
  // Scenarios
  // ************
  task automatic t_bits();
    u_bsx_file_model.mem[7'h20] = 8'hC7;
    u_bsx_file_model.mem[7'h21] = 8'h0A;
    issue({2'b01, 2'b00, 3'd7, 7'h20});
    chk(file_wr, {1'b1, 7'h20, 8'h47});
    chk(zero_we, 1'b0);
    issue({2'b01, 2'b01, 3'd7, 7'h21});
    chk(file_wr, {1'b1, 7'h21, 8'h8A});
  endtask

  task automatic t_skip();
    logic [2:0] fb;
    logic [15:0] wr;
    u_bsx_file_model.mem[7'h22] = 8'h02;
    issue2({2'b01, 2'b10, 3'd0, 7'h22}, {7'h01, 7'h23}, fb, wr);
    chk(fb, 3'b011);
    chk(file_wr.we, 1'b0);
    issue({2'b01, 2'b10, 3'd1, 7'h22});
    chk({flush, busy}, 2'b00);
    u_bsx_file_model.mem[7'h24] = 8'h01;
    issue2({6'h0B, 1'b1, 7'h24}, {7'h01, 7'h25}, fb, wr);
    chk(fb, 3'b011);
    chk(wr, {1'b1, 7'h24, 8'h00});
    chk(file_wr.we, 1'b0);
    u_bsx_file_model.mem[7'h26] = 8'h05;
    issue({6'h0B, 1'b0, 7'h26});
    chk(acc_out, 8'h04);
    chk({flush, busy, zero_we}, 3'b000);
  endtask

  task automatic t_branch();
    logic [2:0] fb;
    logic [15:0] wr;
    @(posedge sys_clk);
    upper_address_latch <= 8'h18;
    issue2({3'h5, 11'h5A5}, {6'h0A, 1'b1, 7'h26}, fb, wr);
    chk(fb, 3'b111);
    chk(pc_target, {2'b11, 11'h5A5});
    chk({file_wr.we, busy, pc_load, flush}, 4'b0000);
  endtask

  task automatic t_arith();
    u_bsx_file_model.mem[7'h28] = 8'hFF;
    u_bsx_file_model.mem[7'h29] = 8'h3C;
    u_bsx_file_model.mem[7'h2A] = 8'hA5;
    issue({6'h0A, 1'b1, 7'h28});
    chk(file_wr, {1'b1, 7'h28, 8'h00});
    chk({zero_we, zero_flag}, 2'b11);
    issue({6'h08, 1'b0, 7'h29});
    chk(acc_out, 8'h3C);
    chk({zero_we, zero_flag}, 2'b10);
    issue({6'h0E, 1'b0, 7'h2A});
    chk({acc_out, zero_we}, {8'h5A, 1'b0});
    issue({6'h0E, 1'b1, 7'h2A});
    chk(file_wr, {1'b1, 7'h2A, 8'h5A});
  endtask

  task automatic t_acc_moves();
    issue({7'h01, 7'h2B});
    chk(file_wr, {1'b1, 7'h2B, 8'h5A});
    chk(zero_we, 1'b0);
    // Legacy loads driven only to prove them; real code writes these directly
    issue(OPC_OPTION_LOAD);
    chk(option_out, 8'h5A);
    issue({11'h00C, 3'd4});
    chk({dir_a_out, dir_c_out}, {DIR_RESET, DIR_RESET});
    issue({11'h00C, 3'd5});
    issue({6'h08, 1'b0, 7'h29});
    issue({11'h00C, 3'd6});
    issue({6'h08, 1'b0, 7'h28});
    issue({11'h00C, 3'd7});
    chk({dir_a_out, dir_b_out}, {8'h5A, 8'h3C});
    chk(dir_c_out, 8'h00);
  endtask

  // Enable low must freeze everything, even with a valid word waiting
  task automatic t_freeze();
    @(posedge sys_clk);
    clk_en      <= 1'b0;
    instr_word  <= {6'h0A, 1'b0, 7'h29};
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    #1;
    chk({acc_out, zero_we, zero_flag}, {8'h00, 1'b0, 1'b1});
    @(posedge sys_clk);
    clk_en <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    chk({acc_out, zero_we, zero_flag}, {8'h3D, 1'b1, 1'b0});
  endtask

  // ************
  // Clock, reset, sequence
  // ************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    upper_address_latch = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    chk({acc_out, option_out}, {ACC_RESET, OPTION_RESET});
    chk({dir_a_out, dir_b_out}, {DIR_RESET, DIR_RESET});
    t_bits();
    t_skip();
    t_branch();
    t_arith();
    t_acc_moves();
    t_freeze();
    tally_and_finish();
  end
endmodule // test_bit_skip_branch_move_exec
